// ==== rtl/ris_defs.svh ====
`ifndef RIS_DEFS_SVH
`define RIS_DEFS_SVH

// ****************************************
// register addresses
// ****************************************
`define RIS_ADDR_STATUS_ONE 8'h24
`define RIS_ADDR_STATUS_TWO 8'h25
`define RIS_ADDR_STATUS_THREE 8'h26
`define RIS_ADDR_MASK_ONE 8'h2A
`define RIS_ADDR_MASK_TWO 8'h2B
`define RIS_ADDR_MASK_THREE 8'h2C

// ****************************************
// reset values
// ****************************************
`define RIS_RST_STATUS_ONE 8'h01
`define RIS_RST_STATUS_TWO 8'h00
`define RIS_RST_STATUS_THREE 8'h00
`define RIS_RST_MASK 8'hFF

// ****************************************
// field positions
// ****************************************
`define RIS_BIT_BANK_ONE_CLR 7
`define RIS_BIT_BANK_ZERO_CLR 6
`define RIS_BIT_FULL 5
`define RIS_BIT_EMPTY 4
`define RIS_BIT_ADDR_ABORT 3
`define RIS_BIT_VCO_CAL 2
`define RIS_BIT_CLK_STABLE 0
`define RIS_BIT_TX_BUF_ERR 7
`define RIS_BIT_RX_BUF_ERR 6
`define RIS_BIT_TX_LEN_ERR 5
`define RIS_BIT_RX_LEN_ERR 4
`define RIS_BIT_SYNC_DET 3
`define RIS_BIT_RF_STATE 2
`define RIS_BIT_DIV_DONE 1
`define RIS_BIT_CCA_DONE 0
`define RIS_BIT_TX_ACC_ONE 7
`define RIS_BIT_TX_ACC_ZERO 6
`define RIS_BIT_CRC_ERR_ONE 5
`define RIS_BIT_CRC_ERR_ZERO 4
`define RIS_BIT_RX_DONE_ONE 3
`define RIS_BIT_RX_DONE_ZERO 2
`define RIS_BIT_TX_DONE_ONE 1
`define RIS_BIT_TX_DONE_ZERO 0
// bits of group one that can reach the pin: 5,4,3,2,0
`define RIS_PIN_BITS_ONE 8'h3D
`define RIS_ALL_BITS 8'hFF
`define RIS_PIN_BITS_TWO 8'hFF
`define RIS_PIN_BITS_THREE 8'hFF
`define RIS_MAX_LEN_4D 11'h081

`endif

// ==== rtl/ris_pkg.sv ====
package ris_pkg;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ris_bus_type;

    typedef struct packed {
        logic tx_req_acc_one;
        logic tx_req_acc_zero;
        logic crc_err_one;
        logic crc_err_zero;
        logic rx_done_one;
        logic rx_done_zero;
        logic tx_done_one;
        logic tx_done_zero;
    } ris_pkt_ev_type;

    typedef struct packed {
        logic tx_buf_err;
        logic rx_buf_err;
        logic sync_det;
        logic rf_state_done;
        logic div_done;
        logic cca_done;
    } ris_link_ev_type;

    typedef struct packed {
        logic [7:0] st_one;
        logic [7:0] st_two;
        logic [7:0] st_three;
        logic [7:0] mask_one;
        logic [7:0] mask_two;
        logic [7:0] mask_three;
        logic [7:0] rdata;
        logic irq_n;
        logic bank_one_clear_pulse;
        logic bank_zero_clear_pulse;
    } ris_state_type;

endpackage

// ==== rtl/ris_top.sv ====
// Operation
// - writing zero clears a status bit
// - status bits record regardless of mask
// - pin held low while unmasked bit pending
// - group one resets 0x01, others zero
// - bank clear bit sets on read start
// - bank clear bits never drive pin
// - bit five: remaining above upper threshold
// - bit four: remaining below lower threshold
// - abort and calibration complete flags
// - transmit buffer access error flag
// - receive buffer access error flag
// - transmit length error in 4d mode
// - receive length error in 4d mode
// - sync-word detection flag
// - rf state transition complete flag
// - diversity and channel assessment complete flags
// - transmit request accepted per buffer
// - crc error per receive buffer
// - reception complete per buffer
// - transmission complete per buffer
// - mask registers, reset all ones
// - indication clears also clear the receive and crc bits of group three
`timescale 1ns/1ps
`include "ris_defs.svh"

module ris_top #(
    parameter int LEN_W = 11,
    parameter int LVL_W = 9
) (
    // ****************************************
    // clock, reset and register bus
    // ****************************************
    input wire logic sys_clk,
    input wire logic rst,
    input wire ris_pkg::ris_bus_type bus,
    output logic [7:0] rdata,
    output logic irq_out_n,
    // ****************************************
    // buffer bank handshake
    // ****************************************
    output logic bank_one_clear,
    output logic bank_zero_clear,
    input wire logic bank_one_read_start,
    input wire logic bank_zero_read_start,
    // ****************************************
    // buffer levels and alarm thresholds
    // ****************************************
    input wire logic [LVL_W-1:0] tx_remaining,
    input wire logic [LVL_W-1:0] rx_remaining,
    input wire logic [LVL_W-1:0] tx_upper_threshold,
    input wire logic [LVL_W-1:0] rx_upper_threshold,
    input wire logic [LVL_W-1:0] tx_lower_threshold,
    input wire logic [LVL_W-1:0] rx_lower_threshold,
    // ****************************************
    // one-shot completion events
    // ****************************************
    input wire logic addr_abort_done,
    input wire logic vco_cal_done,
    input wire logic clk_stable_done,
    // ****************************************
    // length field checks
    // ****************************************
    input wire logic mode_4d,
    input wire logic tx_len_write,
    input wire logic [LEN_W-1:0] tx_len_value,
    input wire logic rx_len_valid,
    input wire logic [LEN_W-1:0] rx_len_value,
    // ****************************************
    // grouped link and packet events
    // ****************************************
    input wire ris_pkg::ris_link_ev_type link_ev,
    input wire ris_pkg::ris_pkt_ev_type pkt_ev,
    // ****************************************
    // indication clears
    // ****************************************
    input wire logic rx_done_indication_clr_one,
    input wire logic rx_done_indication_clr_zero,
    input wire logic crc_ok_clr_one,
    input wire logic crc_ok_clr_zero
);

    // ****************************************
    // helpers
    // ****************************************
    // set wins over clear; write of one leaves bit alone
    function automatic logic [7:0] upd(input logic [7:0] cur, input logic [7:0] set,
                                       input logic wr, input logic [7:0] wd,
                                       input logic [7:0] hwclr);
        logic [7:0] keep;
        keep = wr ? (cur & wd) : cur;
        return ((keep & ~hwclr) | set);
    endfunction

    // the length limit only counts in the 4d packet mode
    function automatic logic len_too_long(input logic [LEN_W-1:0] len);
        return len > LEN_W'(`RIS_MAX_LEN_4D);
    endfunction

    // strict compare: a level equal to its threshold raises nothing
    function automatic logic above(input logic [LVL_W-1:0] lvl,
                                   input logic [LVL_W-1:0] thr);
        return lvl > thr;
    endfunction

    // enabled bits of one group that may pull the pin
    function automatic logic pending(input logic [7:0] st,
                                     input logic [7:0] msk,
                                     input logic [7:0] pin_bits);
        return |(st & msk & pin_bits);
    endfunction

    // write strobe aimed at one offset
    function automatic logic hit(input ris_pkg::ris_bus_type b,
                                 input logic [7:0] addr);
        return b.wr && (b.addr == addr);
    endfunction

    // unmapped offsets read as zero
    function automatic logic [7:0] read_reg(input ris_pkg::ris_state_type st,
                                            input logic [7:0] addr);
        logic [7:0] val;
        unique case (addr)
            `RIS_ADDR_STATUS_ONE: val = st.st_one;
            `RIS_ADDR_STATUS_TWO: val = st.st_two;
            `RIS_ADDR_STATUS_THREE: val = st.st_three;
            `RIS_ADDR_MASK_ONE: val = st.mask_one;
            `RIS_ADDR_MASK_TWO: val = st.mask_two;
            `RIS_ADDR_MASK_THREE: val = st.mask_three;
            default: val = 8'h00;
        endcase
        return val;
    endfunction

    // ****************************************
    // state and decoded strobes
    // ****************************************
    ris_pkg::ris_state_type s_q;
    ris_pkg::ris_state_type s_d;
    logic [7:0] set_one;
    logic [7:0] set_two;
    logic [7:0] set_three;
    logic [7:0] clr_three;
    logic wr_one;
    logic wr_two;
    logic wr_three;
    logic wr_mask_one;
    logic wr_mask_two;
    logic wr_mask_three;
    logic tx_over;
    logic rx_over;
    logic tx_under;
    logic rx_under;
    logic tx_len_err;
    logic rx_len_err;
    logic pend_one;
    logic pend_two;
    logic pend_three;

    // ****************************************
    // write decode
    // ****************************************
    assign wr_one = hit(bus, `RIS_ADDR_STATUS_ONE);
    assign wr_two = hit(bus, `RIS_ADDR_STATUS_TWO);
    assign wr_three = hit(bus, `RIS_ADDR_STATUS_THREE);
    assign wr_mask_one = hit(bus, `RIS_ADDR_MASK_ONE);
    assign wr_mask_two = hit(bus, `RIS_ADDR_MASK_TWO);
    assign wr_mask_three = hit(bus, `RIS_ADDR_MASK_THREE);

    // ****************************************
    // level alarms
    // ****************************************
    // levels, not edges: a flag cleared while the level persists sets again
    assign tx_over = above(tx_remaining, tx_upper_threshold);
    assign rx_over = above(rx_remaining, rx_upper_threshold);
    assign tx_under = above(tx_lower_threshold, tx_remaining);
    assign rx_under = above(rx_lower_threshold, rx_remaining);

    // ****************************************
    // length checks
    // ****************************************
    assign tx_len_err = mode_4d && tx_len_write
        && len_too_long(tx_len_value);
    assign rx_len_err = mode_4d && rx_len_valid
        && len_too_long(rx_len_value);

    // ****************************************
    // group one events
    // ****************************************
    always_comb
    begin
        set_one = 8'h00;
        set_one[`RIS_BIT_BANK_ONE_CLR] = bank_one_read_start;
        set_one[`RIS_BIT_BANK_ZERO_CLR] = bank_zero_read_start;
        set_one[`RIS_BIT_FULL] = tx_over || rx_over;
        set_one[`RIS_BIT_EMPTY] = tx_under || rx_under;
        set_one[`RIS_BIT_ADDR_ABORT] = addr_abort_done;
        set_one[`RIS_BIT_VCO_CAL] = vco_cal_done;
        set_one[`RIS_BIT_CLK_STABLE] = clk_stable_done;
    end

    // ****************************************
    // group two events
    // ****************************************
    always_comb
    begin
        set_two = 8'h00;
        set_two[`RIS_BIT_TX_BUF_ERR] = link_ev.tx_buf_err;
        set_two[`RIS_BIT_RX_BUF_ERR] = link_ev.rx_buf_err;
        set_two[`RIS_BIT_TX_LEN_ERR] = tx_len_err;
        set_two[`RIS_BIT_RX_LEN_ERR] = rx_len_err;
        set_two[`RIS_BIT_SYNC_DET] = link_ev.sync_det;
        set_two[`RIS_BIT_RF_STATE] = link_ev.rf_state_done;
        set_two[`RIS_BIT_DIV_DONE] = link_ev.div_done;
        set_two[`RIS_BIT_CCA_DONE] = link_ev.cca_done;
    end

    // ****************************************
    // group three events
    // ****************************************
    always_comb
    begin
        set_three = 8'h00;
        set_three[`RIS_BIT_TX_ACC_ONE] = pkt_ev.tx_req_acc_one;
        set_three[`RIS_BIT_TX_ACC_ZERO] = pkt_ev.tx_req_acc_zero;
        set_three[`RIS_BIT_CRC_ERR_ONE] = pkt_ev.crc_err_one;
        set_three[`RIS_BIT_CRC_ERR_ZERO] = pkt_ev.crc_err_zero;
        set_three[`RIS_BIT_RX_DONE_ONE] = pkt_ev.rx_done_one;
        set_three[`RIS_BIT_RX_DONE_ZERO] = pkt_ev.rx_done_zero;
        set_three[`RIS_BIT_TX_DONE_ONE] = pkt_ev.tx_done_one;
        set_three[`RIS_BIT_TX_DONE_ZERO] = pkt_ev.tx_done_zero;
        // indication clears only reach the receive and crc bits
        clr_three = 8'h00;
        clr_three[`RIS_BIT_CRC_ERR_ONE] = crc_ok_clr_one;
        clr_three[`RIS_BIT_CRC_ERR_ZERO] = crc_ok_clr_zero;
        clr_three[`RIS_BIT_RX_DONE_ONE] = rx_done_indication_clr_one;
        clr_three[`RIS_BIT_RX_DONE_ZERO] = rx_done_indication_clr_zero;
    end

    // ****************************************
    // pin sources
    // ****************************************
    assign pend_one = pending(s_q.st_one, s_q.mask_one, `RIS_PIN_BITS_ONE);
    assign pend_two = pending(s_q.st_two, s_q.mask_two, `RIS_PIN_BITS_TWO);
    assign pend_three = pending(s_q.st_three, s_q.mask_three, `RIS_PIN_BITS_THREE);

    // ****************************************
    // next state
    // ****************************************
    always_comb
    begin
        s_d = s_q;
        // ****************************************
        // status update, masks play no part
        // ****************************************
        s_d.st_one = upd(s_q.st_one, set_one, wr_one, bus.wdata, 8'h00);
        s_d.st_two = upd(s_q.st_two, set_two, wr_two, bus.wdata, 8'h00);
        s_d.st_three = upd(s_q.st_three, set_three, wr_three, bus.wdata, clr_three);

        // ****************************************
        // bank clear pulses
        // ****************************************
        s_d.bank_one_clear_pulse = 1'b0;
        s_d.bank_zero_clear_pulse = 1'b0;
        if (wr_one)
        begin
            s_d.bank_one_clear_pulse = !bus.wdata[`RIS_BIT_BANK_ONE_CLR];
            s_d.bank_zero_clear_pulse = !bus.wdata[`RIS_BIT_BANK_ZERO_CLR];
        end

        // ****************************************
        // mask writes
        // ****************************************
        if (wr_mask_one)
        begin
            s_d.mask_one = bus.wdata;
        end
        if (wr_mask_two)
        begin
            s_d.mask_two = bus.wdata;
        end
        if (wr_mask_three)
        begin
            s_d.mask_three = bus.wdata;
        end

        // ****************************************
        // read data, held until the next read
        // ****************************************
        if (bus.rd)
        begin
            s_d.rdata = read_reg(s_q, bus.addr);
        end

        // ****************************************
        // pin level
        // ****************************************
        // registered, so the pin never glitches between groups
        s_d.irq_n = !(pend_one || pend_two || pend_three);
    end

    // ****************************************
    // registers
    // ****************************************
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            // status groups
            s_q.st_one <= `RIS_RST_STATUS_ONE;
            s_q.st_two <= `RIS_RST_STATUS_TWO;
            s_q.st_three <= `RIS_RST_STATUS_THREE;
            // every source enabled
            s_q.mask_one <= `RIS_RST_MASK;
            s_q.mask_two <= `RIS_RST_MASK;
            s_q.mask_three <= `RIS_RST_MASK;
            // outputs idle
            s_q.rdata <= 8'h00;
            s_q.irq_n <= 1'b1;
            s_q.bank_one_clear_pulse <= 1'b0;
            s_q.bank_zero_clear_pulse <= 1'b0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign rdata = s_q.rdata;
    assign irq_out_n = s_q.irq_n;
    assign bank_one_clear = s_q.bank_one_clear_pulse;
    assign bank_zero_clear = s_q.bank_zero_clear_pulse;

endmodule // ris_top

// ==== test/ris_assertions.sv ====
`timescale 1ns/1ps
// ****
// port checks
// ****
module ris_assertions #(
    parameter int LEN_W = 11
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire ris_pkg::ris_bus_type bus,
    input wire logic [7:0] rdata,
    input wire logic irq_out_n,
    input wire logic bank_one_clear,
    input wire logic bank_zero_clear,
    input wire logic bank_one_read_start,
    input wire logic mode_4d,
    input wire logic tx_len_write,
    input wire logic [LEN_W-1:0] tx_len_value,
    input wire ris_pkg::ris_pkt_ev_type pkt_ev
);
    wire logic [7:0] pk = pkt_ev;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    reset_level_a: assert property ($fell(rst) |-> irq_out_n && rdata == 8'h00)
        else $error("outputs off after reset");
    clr_one_cause_a: assert property (bank_one_clear |->
        $past(bus.wr && bus.addr == 8'h24 && !bus.wdata[7])) else $error("stray clear one");
    clr_zero_cause_a: assert property (bank_zero_clear |->
        $past(bus.wr && bus.addr == 8'h24 && !bus.wdata[6])) else $error("stray clear zero");
    unmapped_read_a: assert property (bus.rd && bus.addr == 8'h2D |=> rdata == 8'h00)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (!bus.rd |=> $stable(rdata)) else $error("read data moved");
    pkt_read_a: assert property (((pk & 8'hC3) != 8'h00) ##1 !bus.wr
        ##1 (bus.rd && !bus.wr && bus.addr == 8'h26)
        |=> (rdata & $past(pk, 3) & 8'hC3) == ($past(pk, 3) & 8'hC3))
        else $error("packet event lost");
    len_err_a: assert property ((mode_4d && tx_len_write && tx_len_value > 11'h081)
        ##1 !bus.wr ##1 (bus.rd && !bus.wr && bus.addr == 8'h25) |=> rdata[5])
        else $error("no len error");
    bank_set_a: assert property (bank_one_read_start ##1 !bus.wr
        ##1 (bus.rd && !bus.wr && bus.addr == 8'h24) |=> rdata[7])
        else $error("bank bit not set");
endmodule // ris_assertions

// ==== test/ris_host_model.sv ====
`timescale 1ns/1ps
// ****
// host side of the register bus
// ****
module ris_host_model (
    input wire logic sys_clk,
    input wire logic [7:0] rdata,
    output ris_pkg::ris_bus_type bus
);
    initial bus = '0;
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    // each write holds the strobe for one clock, then releases it
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        tick();
        bus = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
        tick();
        bus.wr = 1'b0;
        // released data must not keep its last value
        bus.wdata = ~v;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        tick();
        bus = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        tick();
        bus.rd = 1'b0;
        v = rdata;
    endtask
endmodule // ris_host_model

// ==== test/test_radio_interrupt_status.sv ====
`timescale 1ns/1ps
module test_radio_interrupt_status;
    logic sys_clk = 1'b0, rst = 1'b1, irq_out_n, b1c, b0c, b1s = 0, b0s = 0, m4d = 0, txw = 0;
    logic rxv = 0, ab = 0, vc = 0, cs = 0, ic1 = 0, ic0 = 0, cc1 = 0, cc0 = 0;
    logic [7:0] rdata, d;
    logic [8:0] txr = 0, rxr = 0, txu = 9'h1FF, rxu = 9'h1FF, txl = 0, rxl = 0;
    logic [10:0] txv = 0, rxlv = 0;
    ris_pkg::ris_link_ev_type lk = '0;
    ris_pkg::ris_pkt_ev_type pk = '0;
    ris_pkg::ris_bus_type bus;
    int err_count = 0, checked = 0, cyc = 0;
    ris_host_model i_ris_host_model (.sys_clk(sys_clk), .rdata(rdata), .bus(bus));
    ris_top i_ris_top (.sys_clk(sys_clk), .rst(rst), .bus(bus), .rdata(rdata),
        .irq_out_n(irq_out_n), .bank_one_clear(b1c), .bank_zero_clear(b0c),
        .bank_one_read_start(b1s), .bank_zero_read_start(b0s), .tx_remaining(txr),
        .rx_remaining(rxr), .tx_upper_threshold(txu), .rx_upper_threshold(rxu),
        .tx_lower_threshold(txl), .rx_lower_threshold(rxl), .addr_abort_done(ab),
        .vco_cal_done(vc), .clk_stable_done(cs), .mode_4d(m4d), .tx_len_write(txw),
        .tx_len_value(txv), .rx_len_valid(rxv), .rx_len_value(rxlv), .link_ev(lk), .pkt_ev(pk),
        .rx_done_indication_clr_one(ic1), .rx_done_indication_clr_zero(ic0),
        .crc_ok_clr_one(cc1), .crc_ok_clr_zero(cc0));
    always #4 sys_clk = ~sys_clk;
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e)
        begin
            err_count++;
            $display("Error at %0t: saw %h expected %h", $time, s, e);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        i_ris_host_model.rd(a, d);
        chk(d, e);
    endtask
    task automatic t_reset();
        rdchk(8'h24, 8'h01);
        rdchk(8'h25, 8'h00);
        rdchk(8'h26, 8'h00);
        rdchk(8'h2A, 8'hFF);
        rdchk(8'h2C, 8'hFF);
        rdchk(8'h2D, 8'h00);
        chk({7'h00, irq_out_n}, 8'h00);
        i_ris_host_model.wr(8'h24, 8'hFF);
        rdchk(8'h24, 8'h01);
        i_ris_host_model.wr(8'h24, 8'hFE);
        rdchk(8'h24, 8'h00);
        chk({7'h00, irq_out_n}, 8'h01);
        $display("reset and clear done");
    endtask
    task automatic t_grp3();
        i_ris_host_model.wr(8'h2C, 8'h00);
        tick();
        pk = '1;
        tick();
        pk = '0;
        rdchk(8'h26, 8'hFF);
        chk({7'h00, irq_out_n}, 8'h01);
        i_ris_host_model.wr(8'h2C, 8'h01);
        tick();
        chk({7'h00, irq_out_n}, 8'h00);
        {ic0, cc1} = 2'b11;
        tick();
        {ic0, cc1} = 2'b00;
        rdchk(8'h26, 8'hDB);
        i_ris_host_model.wr(8'h26, 8'h00);
        rdchk(8'h26, 8'h00);
        chk({7'h00, irq_out_n}, 8'h01);
        $display("group three done");
    endtask
    task automatic t_grp2();
        tick();
        {m4d, txw, rxv, txv, rxlv, lk} = {3'b111, 11'h082, 11'h081, 6'h3F};
        tick();
        {txw, rxv, lk} = '0;
        rdchk(8'h25, 8'hEF);
        i_ris_host_model.wr(8'h25, 8'h00);
        {m4d, rxv, rxlv} = {2'b01, 11'h0C8};
        tick();
        rxv = 1'b0;
        rdchk(8'h25, 8'h00);
        {m4d, rxv, rxlv} = {2'b11, 11'h082};
        tick();
        rxv = 1'b0;
        rdchk(8'h25, 8'h10);
        i_ris_host_model.wr(8'h25, 8'h00);
        $display("group two done");
    endtask
    task automatic t_grp1();
        i_ris_host_model.wr(8'h2A, 8'hC0);
        {b1s, b0s, ab, vc, cs, txr, txu, rxr, rxl} = {5'h1F, 9'h00A, 9'h009, 9'h001, 9'h002};
        tick();
        {b1s, b0s, ab, vc, cs, txu, rxl} = {5'h00, 9'h1FF, 9'h000};
        rdchk(8'h24, 8'hFD);
        chk({7'h00, irq_out_n}, 8'h01);
        i_ris_host_model.wr(8'h24, 8'h3F);
        chk({6'h00, b1c, b0c}, 8'h03);
        rdchk(8'h24, 8'h3D);
        $display("group one done");
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_count++;
            report_and_stop();
        end
    end
    initial
    begin
        tick();
        tick();
        rst = 1'b0;
        t_reset();
        t_grp3();
        t_grp2();
        t_grp1();
        report_and_stop();
    end
endmodule // test_radio_interrupt_status
bind ris_top ris_assertions #(.LEN_W(LEN_W)) i_ris_assertions (.sys_clk(sys_clk), .rst(rst),
    .bus(bus), .rdata(rdata), .irq_out_n(irq_out_n), .bank_one_clear(bank_one_clear),
    .bank_zero_clear(bank_zero_clear), .bank_one_read_start(bank_one_read_start),
    .mode_4d(mode_4d), .tx_len_write(tx_len_write), .tx_len_value(tx_len_value),
    .pkt_ev(pkt_ev));
